// ### core/ige_encoder.sv
// gray decoder turning coil states into relative count and angle
// assumes coil inputs arrive asynchronously from the sensing channels
//
// Operation
// [RL1] coil bit is 1 when fully covered by the target, 0 when clear
// [RL2] two coils give four positions 90 deg apart: 10, 11, 01, 00
// [RL3] N positions: coil separation 360/N, target span twice that, N/4 targets
// [RL4] each target yields four gray states; eight targets give 32 positions
// [RL5] equivalent coil placements every four separations decode identically
// [RL6] with reference coils enabled each must read inverse of its main coil
// [RL7] reference mode states A,Aref,B,Bref: 0101, 1001, 1010, 0110
// [RL8] counter moves by exactly one per detected step, sign by direction
// [RL9] angle stays within one turn, always a multiple of coil separation
// [RL10] encoder channels take one event type: covered when enter threshold crossed
// [RL11] forward gray step increments, reverse decrements, double change ignored
`include "ige_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module ige_encoder (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// coil covered states from the channel logic, plus mode
	input wire ige_pkg::ige_coils_s coils,
	input wire logic refEnable,
	// results
	output ige_pkg::ige_result_s result
);
	logic [1:0] rstSync;
	logic rstInt;
	ige_pkg::ige_coils_s coilMeta;
	ige_pkg::ige_coils_s coilSync;
	logic [1:0] syncFill;
	ige_pkg::ige_state_e state;
	logic [1:0] prevCode;
	logic [`IGE_IDX_W-1:0] posIdx;
	logic [`IGE_CNT_W-1:0] count;
	logic [`IGE_ANG_W-1:0] angle;
	logic stepUp;
	logic stepDown;
	logic refFault;

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rstSync <= 2'h0;
		else
			rstSync <= {rstSync[0], 1'b1};
	end
	assign rstInt = rstSync[1];

	// coil inputs pass two flops before any decoding
	always_ff @(posedge clk or negedge rstInt)
	begin
		if (!rstInt)
		begin
			coilMeta <= 4'h0;
			coilSync <= 4'h0;
			syncFill <= 2'h0;
		end
		else
		begin
			coilMeta <= coils;
			coilSync <= coilMeta;
			syncFill <= {syncFill[0], 1'b1}; // marks real samples in the pair
		end
	end

	// covered bit is used as-is: one event type per encoder coil
	wire logic a = coilSync.coilA; // RL1 RL10
	wire logic b = coilSync.coilB; // RL1 RL10
	// reference coils must read inverse of their main coils
	wire logic refOk = (coilSync.coilARef == ~a) &&
		(coilSync.coilBRef == ~b); // RL6
	// in reference mode the gray code is (A,B) shifted: 00,10,11,01 is 0..270
	// which is the two-coil sequence read one step earlier
	wire logic [1:0] code = {a, b}; // RL7
	wire logic codeValid = !refEnable || refOk; // RL6
	// the sync pair still holds its reset zeros for two cycles; seeding
	// from those would count a false step once the real coils arrive
	wire logic syncReady = syncFill[1];

	// forward order 10 -> 11 -> 01 -> 00 -> 10
	function automatic logic [1:0] ige_next_fwd(input logic [1:0] c);
		case (c)
			`IGE_GRAY_P1: ige_next_fwd = `IGE_GRAY_P2;
			`IGE_GRAY_P2: ige_next_fwd = `IGE_GRAY_P3;
			`IGE_GRAY_P3: ige_next_fwd = `IGE_GRAY_P4;
			default: ige_next_fwd = `IGE_GRAY_P1;
		endcase
	endfunction : ige_next_fwd

	// direction decode; a double change matches neither and is ignored
	wire logic changed = (code != prevCode);
	wire logic isFwd = changed && (code == ige_next_fwd(prevCode)); // RL2 RL11
	wire logic isRev = changed && (prevCode == ige_next_fwd(code)); // RL11
	// placement at any 4n separation repeats the same four-state cycle
	wire logic doUp = codeValid && isFwd; // RL5
	wire logic doDown = codeValid && isRev; // RL5
	// position index wraps after N = 4 states x N/4 targets
	wire logic [`IGE_IDX_W-1:0] next_posIdx = doUp ? posIdx + 1'b1 :
		doDown ? posIdx - 1'b1 : posIdx; // RL3 RL4
	wire logic [`IGE_CNT_W-1:0] next_count = doUp ? count + 1'b1 :
		doDown ? count - 1'b1 : count; // RL8
	// angle in hundredths of a degree, index times coil separation
	wire logic [31:0] angleWide = next_posIdx * `IGE_COIL_SEP; // RL9
	wire logic [`IGE_ANG_W-1:0] next_angle = angleWide[`IGE_ANG_W-1:0];

	// tracking state: first valid code seeds without counting
	always_ff @(posedge clk or negedge rstInt)
	begin
		if (!rstInt)
		begin
			state <= ige_pkg::IGE_S_INIT;
			prevCode <= 2'h0;
			posIdx <= `IGE_IDX_RST;
			count <= `IGE_CNT_RST;
			angle <= `IGE_ANG_RST;
			stepUp <= 1'b0;
			stepDown <= 1'b0;
			refFault <= 1'b0;
		end
		else
		begin
			refFault <= refEnable && !refOk;
			case (state)
				ige_pkg::IGE_S_INIT:
				begin
					stepUp <= 1'b0;
					stepDown <= 1'b0;
					if (codeValid && syncReady)
					begin
						prevCode <= code;
						state <= ige_pkg::IGE_S_RUN;
					end
				end
				ige_pkg::IGE_S_RUN:
				begin
					stepUp <= doUp;
					stepDown <= doDown;
					if (codeValid)
						prevCode <= code;
					posIdx <= next_posIdx;
					count <= next_count;
					angle <= next_angle;
				end
				default:
					state <= ige_pkg::IGE_S_INIT;
			endcase
		end
	end

	// results leave straight from flops
	always_comb
	begin
		result.count = count;
		result.angle = angle;
		result.stepUp = stepUp;
		result.stepDown = stepDown;
		result.refFault = refFault;
	end

	// one step moves the counter by exactly one
	step_up_a: assert property (@(posedge clk) // RL8
		disable iff (!rstInt)
		stepUp |-> count == $past(count) + 16'h0001)
		else $error("count did not rise by one");
	step_down_a: assert property (@(posedge clk) // RL8
		disable iff (!rstInt)
		stepDown |-> count == $past(count) - 16'h0001)
		else $error("count did not fall by one");
	// count holds without a step
	count_hold_a: assert property (@(posedge clk) // RL11
		disable iff (!rstInt)
		(!stepUp && !stepDown && $past(rstInt)) |-> $stable(count))
		else $error("count moved without step");
	// angle multiple of separation and below a full turn
	angle_range_a: assert property (@(posedge clk) // RL9
		disable iff (!rstInt)
		angle < 16'h8ca0 && (angle % 16'h0465) == 16'h0000)
		else $error("angle out of grid");
	// a double bit change never counts
	double_change_a: assert property (@(posedge clk) // RL11
		disable iff (!rstInt)
		(state == ige_pkg::IGE_S_RUN && (code ^ prevCode) == 2'h3)
		|=> !stepUp && !stepDown)
		else $error("double change counted");
	// forward gray step gives an up pulse next cycle
	fwd_step_a: assert property (@(posedge clk) // RL2
		disable iff (!rstInt)
		(state == ige_pkg::IGE_S_RUN && codeValid && prevCode == 2'h2 &&
		code == 2'h3) |=> stepUp)
		else $error("forward step missed");
	// with refEnable set, an invalid reference pair never counts
	ref_block_a: assert property (@(posedge clk) // RL6
		disable iff (!rstInt)
		(refEnable && !refOk) |=> !stepUp && !stepDown)
		else $error("counted on bad reference");
	// never both directions
	one_dir_a: assert property (@(posedge clk) // RL11
		disable iff (!rstInt)
		!(stepUp && stepDown))
		else $error("both directions");

	// named pieces of a decoded step and its answer one cycle later
	sequence run_valid_seq;
		state == ige_pkg::IGE_S_RUN && codeValid;
	endsequence
	sequence up_pulse_seq;
		stepUp && !stepDown;
	endsequence
	sequence down_pulse_seq;
		stepDown && !stepUp;
	endsequence
	// wrap of the gray cycle: 00 -> 10 counts up, 10 -> 00 counts down
	fwd_wrap_a: assert property (@(posedge clk) // RL11
		disable iff (!rstInt)
		run_valid_seq ##0 (prevCode == 2'h0 && code == 2'h2)
		|=> up_pulse_seq)
		else $error("forward wrap missed");
	rev_wrap_a: assert property (@(posedge clk) // RL11
		disable iff (!rstInt)
		run_valid_seq ##0 (prevCode == 2'h2 && code == 2'h0)
		|=> down_pulse_seq)
		else $error("reverse wrap missed");
	// reverse step inside the cycle, 11 -> 10
	rev_step_a: assert property (@(posedge clk) // RL11
		disable iff (!rstInt)
		run_valid_seq ##0 (prevCode == 2'h3 && code == 2'h2)
		|=> down_pulse_seq)
		else $error("reverse step missed");
	// angle moves one separation per step and wraps at a full turn
	angle_up_a: assert property (@(posedge clk) // RL9
		disable iff (!rstInt)
		stepUp |-> angle == ($past(angle) == 16'h883b ? 16'h0000 :
		$past(angle) + 16'h0465))
		else $error("angle did not advance one separation");
	angle_down_a: assert property (@(posedge clk) // RL9
		disable iff (!rstInt)
		stepDown |-> angle == ($past(angle) == 16'h0000 ? 16'h883b :
		$past(angle) - 16'h0465))
		else $error("angle did not retreat one separation");
	// with refEnable set, a broken reference pair raises the fault flag next cycle
	ref_fault_a: assert property (@(posedge clk) // RL6
		disable iff (!rstInt)
		(refEnable && !refOk) |=> refFault)
		else $error("reference fault not flagged");
	// the seeding cycle never moves the count
	seed_quiet_a: assert property (@(posedge clk) // RL8
		disable iff (!rstInt)
		state == ige_pkg::IGE_S_INIT |=> $stable(count))
		else $error("count moved while seeding");
endmodule : ige_encoder
`default_nettype wire

// ### core/ige_cfg.svh
// constants for the gray relative encoder: sizes, codes, reset values
// assumes inclusion by bare name from the package and design files
`ifndef IGE_CFG_SVH
`define IGE_CFG_SVH
// positions per revolution and derived geometry
`define IGE_POS_PER_REV 32
`define IGE_TARGETS (`IGE_POS_PER_REV / 4)
`define IGE_STATES_PER_TARGET 4
// coil separation in hundredths of a degree, 360 deg / N
`define IGE_FULL_TURN 36000
`define IGE_COIL_SEP (`IGE_FULL_TURN / `IGE_POS_PER_REV)
// gray codes of coil A, coil B for positions one to four
`define IGE_GRAY_P1 2'h2
`define IGE_GRAY_P2 2'h3
`define IGE_GRAY_P3 2'h1
`define IGE_GRAY_P4 2'h0
// widths and reset values
`define IGE_CNT_W 16
`define IGE_ANG_W 16
`define IGE_IDX_W 5
`define IGE_CNT_RST 16'h0000
`define IGE_ANG_RST 16'h0000
`define IGE_IDX_RST 5'h00
`endif

// ### core/ige_pkg.sv
// types for the gray relative encoder
// assumes ige_cfg.svh on the include path
`default_nettype none
`include "ige_cfg.svh"
package ige_pkg;
	// coil states from the channel logic, 1 = covered
	typedef struct packed {
		logic coilA;
		logic coilARef;
		logic coilB;
		logic coilBRef;
	} ige_coils_s;
	// results to the output logic
	typedef struct packed {
		logic [`IGE_CNT_W-1:0] count;
		logic [`IGE_ANG_W-1:0] angle;
		logic stepUp;
		logic stepDown;
		logic refFault;
	} ige_result_s;
	typedef enum logic [1:0] {
		IGE_S_INIT,
		IGE_S_RUN
	} ige_state_e;
endpackage : ige_pkg
`default_nettype wire

// ### sim/ige_dial_model.sv
// dial model: coil covered states for one gray phase of the target
// assumes the bench moves phase just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module ige_dial_model (
	// dial phase and reference fault injection
	input wire logic [1:0] phase,
	input wire logic refBad,
	// coil states
	output wire ige_pkg::ige_coils_s coils
);
	wire logic a;
	wire logic b;
	// phases 0..3 give A,B of 10, 11, 01, 00; 1 = covered
	assign a = ~phase[1];
	assign b = phase[1] ^ phase[0];
	// refs read inverse of their main coil unless a fault is injected
	assign coils = {a, ~(a ^ refBad), b, ~(b ^ refBad)};
endmodule : ige_dial_model
`default_nettype wire

// ### sim/tb_inductive_gray_relative_encoder.sv
// bench for the gray relative encoder: steps the dial model both ways
// assumes the design sources and the dial model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_inductive_gray_relative_encoder;
	logic clk;
	logic rst_n;
	logic refEnable;
	logic refBad;
	logic [1:0] phase;
	ige_pkg::ige_coils_s coils;
	ige_pkg::ige_result_s result;
	int miscompares;
	int compares;
	logic [15:0] expCnt;
	logic [4:0] idx;
	ige_dial_model model_u (.phase(phase), .refBad(refBad), .coils(coils));
	ige_encoder dut_u (.clk(clk), .rst_n(rst_n), .coils(coils),
		.refEnable(refEnable), .result(result));
	// free running 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	// move the dial by d phases; dc is the expected count change
	task automatic step(input logic [1:0] d, input logic [15:0] dc);
		@(posedge clk) phase <= phase + d;
		repeat (3) @(posedge clk);
		#1;
		check({15'h0, result.stepUp}, {15'h0, dc == 16'h0001});
		check({15'h0, result.stepDown}, {15'h0, dc == 16'hffff});
		expCnt = expCnt + dc;
		idx = idx + dc[4:0];
		repeat (2) @(posedge clk);
		check(result.count, expCnt);
		check(result.angle, {11'h0, idx} * 16'h0465);
	endtask : step
	// a full turn and one more forward, angle wraps after 32
	task automatic fwd_turn;
		repeat (33) step(2'h1, 16'h0001);
	endtask : fwd_turn
	// backwards past zero, count wraps downward
	task automatic rev_turn;
		repeat (40) step(2'h3, 16'hffff);
	endtask : rev_turn
	// both coils at once is ignored, next single step still counts
	task automatic double_jump;
		step(2'h2, 16'h0000);
		step(2'h1, 16'h0001);
	endtask : double_jump
	// reference coils: valid codes count, broken refs raise a fault only once refEnable is set
	task automatic ref_mode;
		@(posedge clk) refBad <= 1'b1;
		step(2'h1, 16'h0001);
		check({15'h0, result.refFault}, 16'h0000);
		@(posedge clk) refBad <= 1'b0;
		refEnable <= 1'b1;
		repeat (4) step(2'h1, 16'h0001);
		@(posedge clk) refBad <= 1'b1;
		repeat (5) @(posedge clk);
		check({15'h0, result.refFault}, 16'h0001);
		step(2'h1, 16'h0000);
		@(posedge clk) refBad <= 1'b0;
		expCnt = expCnt + 16'h0001;
		idx = idx + 5'h01;
		repeat (5) @(posedge clk);
		check({15'h0, result.refFault}, 16'h0000);
		check(result.count, expCnt);
	endtask : ref_mode
	// reset, then scenarios
	initial
	begin
		rst_n = 1'b0;
		refEnable = 1'b0;
		refBad = 1'b0;
		phase = 2'h0;
		miscompares = 0;
		compares = 0;
		expCnt = 16'h0000;
		idx = 5'h00;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		check(result.count, 16'h0000);
		fwd_turn();
		rev_turn();
		double_jump();
		ref_mode();
		complete_run();
	end
endmodule : tb_inductive_gray_relative_encoder
`default_nettype wire
